// ==== hdl/lcd_clk_div.sv ====
// Purpose: Selects the LCD source clock and divides it into scan-step enables.
// Assumes: Oscillator inputs are one-cycle tick pulses synchronous to pclk.
// Notes: Counters clear while stopped so a restart begins a full period.
`timescale 1ns/1ps
`default_nettype none
module lcd_clk_div #(
  parameter lcd_pkg::clk_src_e CLK_SRC = lcd_pkg::SRC_SYS_DIV4,
  parameter int DIV_EXP = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic timekeeping_oscillator_tick,
  input wire logic watchdog_oscillator_tick,
  output logic scan_tick
);
  localparam int PERIOD = lcd_pkg::SYS_DIV4_CNT << DIV_EXP;
  logic [1:0] pre_q;
  logic [7:0] div_q;
  logic sys4_tick;
  logic src_tick;
  logic div_end;
  logic [15:0] gap_q;
  logic seen_q;

  assign sys4_tick = (pre_q == lcd_pkg::PRE_LAST);
  assign src_tick = (CLK_SRC == lcd_pkg::SRC_SYS_DIV4) ? sys4_tick :
                    (CLK_SRC == lcd_pkg::SRC_TIMEKEEP) ? timekeeping_oscillator_tick :
                    watchdog_oscillator_tick;
  assign div_end = (div_q == 8'((1 << DIV_EXP) - 1));
  assign scan_tick = run & src_tick & div_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 2'h0;
      div_q <= 8'h00;
    end else if (!run) begin
      pre_q <= 2'h0;
      div_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 2'h1;
      if (src_tick) div_q <= div_end ? 8'h00 : div_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= scan_tick ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= run & (seen_q | scan_tick);
    end
  end

  chk_scan_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    (CLK_SRC == lcd_pkg::SRC_SYS_DIV4) && scan_tick && seen_q |-> gap_q == 16'(PERIOD - 1))
    else $error("scan step spacing differs from the divided source period");
endmodule // lcd_clk_div
`default_nettype wire

// ==== hdl/lcd_display_memory_driver.sv ====
// Purpose: Display memory, banked data window and panel scan of a segment LCD driver.
// Assumes: APB slave with zero wait states; cpu_halt is synchronous to pclk.
// Notes: Display address 40h+s holds segment s; bit c of that byte is common c.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcd_display_memory_driver #(
  parameter int DUTY = 4,
  parameter bit THIRD_BIAS = 1'b1,
  parameter bit LOW_VOLT = 1'b0,
  parameter int DIV_EXP = 4,
  parameter lcd_pkg::clk_src_e CLK_SRC = lcd_pkg::SRC_SYS_DIV4,
  parameter bit HALT_KEEP_ON = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_halt,
  input wire logic timekeeping_oscillator_tick,
  input wire logic watchdog_oscillator_tick,
  output logic bank_select_bit,
  output var lcd_pkg::lcd_drive_s drive
);
  ////////////////////////////////////////////////////////////////////////////
  // Build options resolved.

  // The low-voltage variant has no third-bias rail, so the option is ignored there.
  localparam bit BIAS_THIRD = THIRD_BIAS && !LOW_VOLT;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic bank_q;
  logic [7:0] ptr_q;
  logic [lcd_pkg::MEM_WORDS-1:0][7:0] disp_mem_q;
  logic [lcd_pkg::MEM_WORDS-1:0][7:0] gp_mem_q;
  logic [31:0] prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic setup;
  logic access;
  logic wr;
  logic hit_ctrl;
  logic hit_ptr;
  logic hit_ind;
  logic hit_stat;
  logic hit_win;
  logic mapped;
  logic [11:0] win_rel;
  logic [5:0] win_idx;
  logic ptr_in;
  logic [5:0] ptr_idx;
  logic ind_disp;
  logic ind_gp;
  logic wr_disp;
  logic wr_gp_ind;
  logic wr_gp_win;

  function automatic logic in_disp_range(input logic [7:0] a);
    return a >= lcd_pkg::DISP_LO && a <= lcd_pkg::DISP_HI;
  endfunction

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign hit_ctrl = (paddr == lcd_pkg::OFF_CTRL);
  assign hit_ptr = (paddr == lcd_pkg::OFF_PTR);
  assign hit_ind = (paddr == lcd_pkg::OFF_IND);
  assign hit_stat = (paddr == lcd_pkg::OFF_STAT);
  assign hit_win = (paddr >= lcd_pkg::OFF_WIN) && (paddr <= lcd_pkg::OFF_WIN_LAST) &&
                   (paddr[1:0] == 2'h0);
  assign mapped = hit_ctrl | hit_ptr | hit_ind | hit_stat | hit_win;
  assign win_rel = paddr - lcd_pkg::OFF_WIN;
  assign win_idx = win_rel[7:2];
  assign ptr_in = in_disp_range(ptr_q);
  assign ptr_idx = 6'(ptr_q - lcd_pkg::DISP_LO);
  assign ind_disp = bank_q & ptr_in;
  assign ind_gp = ~bank_q & ptr_in;
  assign wr_disp = wr & hit_ind & ind_disp;
  assign wr_gp_ind = wr & hit_ind & ind_gp;
  // The direct window always lands in general memory; display bytes need the pointer.
  assign wr_gp_win = wr & hit_win;

  assign pready = 1'b1;
  // Status is read only, so writing it is flagged like an unmapped address.
  assign pslverr = access & (~mapped | (hit_stat & pwrite));
  assign prdata = prdata_q;
  assign bank_select_bit = bank_q;

  ////////////////////////////////////////////////////////////////////////////
  // Scan chain.

  logic scan_run;
  logic scan_step;
  logic [lcd_pkg::SEG_NUM-1:0] seg_bits;
  lcd_pkg::scan_status_s scan_status;

  assign scan_run = ~(cpu_halt & ~HALT_KEEP_ON);

  // The scan reads the live memory every clock, so a write shows on the pins one edge after it lands.
  always_comb begin
    seg_bits = '0;
    for (int s = 0; s < lcd_pkg::SEG_NUM; s++) begin
      seg_bits[s] = disp_mem_q[s][scan_status.com];
    end
  end

  lcd_clk_div #(
    .CLK_SRC(CLK_SRC),
    .DIV_EXP(DIV_EXP)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(scan_run),
    .timekeeping_oscillator_tick(timekeeping_oscillator_tick),
    .watchdog_oscillator_tick(watchdog_oscillator_tick),
    .scan_tick(scan_step)
  );

  lcd_scan #(
    .DUTY(DUTY),
    .THIRD_BIAS(BIAS_THIRD)
  ) u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .enable(scan_run),
    .step(scan_step),
    .seg_bits(seg_bits),
    .status(scan_status),
    .drive(drive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [31:0] rd_value;

  always_comb begin
    rd_value = lcd_pkg::RD_ZERO;
    if (hit_ctrl) rd_value[0] = bank_q;
    if (hit_ptr) rd_value[7:0] = ptr_q;
    if (hit_ind && ind_disp) rd_value[7:0] = disp_mem_q[ptr_idx];
    if (hit_ind && ind_gp) rd_value[7:0] = gp_mem_q[ptr_idx];
    if (hit_stat) rd_value[3:0] = scan_status;
    if (hit_win) rd_value[7:0] = gp_mem_q[win_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= lcd_pkg::BANK_RST;
      ptr_q <= lcd_pkg::PTR_RST;
      prdata_q <= lcd_pkg::RD_ZERO;
    end else begin
      if (wr && hit_ctrl) bank_q <= pwdata[0];
      if (wr && hit_ptr) ptr_q <= pwdata[7:0];
      if (setup && !pwrite) prdata_q <= rd_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_mem_q <= {lcd_pkg::MEM_WORDS{lcd_pkg::MEM_RST}};
      gp_mem_q <= {lcd_pkg::MEM_WORDS{lcd_pkg::MEM_RST}};
    end else begin
      if (wr_disp) disp_mem_q[ptr_idx] <= pwdata[7:0];
      if (wr_gp_ind) gp_mem_q[ptr_idx] <= pwdata[7:0];
      if (wr_gp_win) gp_mem_q[win_idx] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_display_write;
    wr && hit_ind && bank_q && ptr_in;
  endsequence

  sequence s_halted_off;
    (!HALT_KEEP_ON && cpu_halt) [*3];
  endsequence

  chk_display_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    s_display_write |=> disp_mem_q[$past(ptr_idx)] == $past(pwdata[7:0]))
    else $error("indirect write with bank one did not reach display memory");
  chk_bank_zero_safe: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ind && !bank_q |=> $stable(disp_mem_q))
    else $error("bank zero access altered display memory");
  chk_bank_zero_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ind && !bank_q && ptr_in |=> gp_mem_q[$past(ptr_idx)] == $past(pwdata[7:0]))
    else $error("bank zero write missed general memory");
  chk_direct_no_display: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_win |=> $stable(disp_mem_q))
    else $error("direct window write altered display memory");
  chk_range_bounds: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ind && !ptr_in |=> $stable(disp_mem_q) && $stable(gp_mem_q))
    else $error("pointer outside the display area changed a memory");
  chk_halt_blank: assert property (@(posedge pclk) disable iff (!presetn)
    s_halted_off |-> drive == '0)
    else $error("display not blanked to ground during halt");
  chk_keep_scanning: assert property (@(posedge pclk) disable iff (!presetn)
    HALT_KEEP_ON |-> scan_run)
    else $error("scan stopped although it must keep running in halt");
  chk_half_bias_rails: assert property (@(posedge pclk) disable iff (!presetn)
    !BIAS_THIRD |-> drive.com[0] != lcd_pkg::LVL_HIGH && drive.seg[0] != lcd_pkg::LVL_HIGH)
    else $error("third-bias rail used in half bias");
  chk_fetch_follows: assert property (@(posedge pclk) disable iff (!presetn)
    !scan_status.blank && !scan_status.neg && !disp_mem_q[0][scan_status.com]
    && $stable(scan_status) |=> drive.seg[0] != lcd_pkg::LVL_GND)
    else $error("dark pixel driven as lit");
  chk_common_count: assert property (@(posedge pclk) disable iff (!presetn)
    scan_status.com <= 2'(DUTY - 1))
    else $error("common index beyond selected duty");
  chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    access && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  chk_read_display: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_ind && ind_disp |=> prdata == {24'h00_0000, $past(disp_mem_q[ptr_idx])})
    else $error("indirect read of display memory returned wrong byte");
endmodule // lcd_display_memory_driver
`default_nettype wire

// ==== hdl/lcd_scan.sv ====
// Purpose: Steps the commons and builds common and segment drive levels.
// Assumes: seg_bits already holds the display bits of the active common.
// Notes: Each common period has a positive and a negative half; with third bias no pixel sees DC, but half bias holds idle commons at LOW in both.
`timescale 1ns/1ps
`default_nettype none
module lcd_scan #(
  parameter int DUTY = 4,
  parameter bit THIRD_BIAS = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic step,
  input wire logic [lcd_pkg::SEG_NUM-1:0] seg_bits,
  output lcd_pkg::scan_status_s status,
  output var lcd_pkg::lcd_drive_s drive
);
  lcd_pkg::scan_e state_q, state_d;
  logic [1:0] com_q, com_d;
  logic [1:0] com_last;
  logic neg;
  lcd_pkg::lcd_drive_s drive_d;

  assign com_last = 2'(DUTY - 1);
  assign neg = (state_q == lcd_pkg::ST_NEG);
  assign status = '{blank: (state_q == lcd_pkg::ST_OFF), neg: neg, com: com_q};

  function automatic logic [1:0] com_lvl(input logic act, input logic n);
    if (act) return n ? lcd_pkg::LVL_GND : lcd_pkg::LVL_TOP;
    return (THIRD_BIAS && n) ? lcd_pkg::LVL_HIGH : lcd_pkg::LVL_LOW;
  endfunction

  function automatic logic [1:0] seg_lvl(input logic on, input logic n);
    if (on) return n ? lcd_pkg::LVL_TOP : lcd_pkg::LVL_GND;
    if (THIRD_BIAS) return n ? lcd_pkg::LVL_LOW : lcd_pkg::LVL_HIGH;
    return n ? lcd_pkg::LVL_GND : lcd_pkg::LVL_TOP;
  endfunction

  always_comb begin
    state_d = state_q;
    com_d = com_q;
    case (state_q)
      lcd_pkg::ST_OFF: if (enable) state_d = lcd_pkg::ST_POS;
      lcd_pkg::ST_POS: begin
        if (!enable) state_d = lcd_pkg::ST_OFF;
        else if (step) state_d = lcd_pkg::ST_NEG;
      end
      lcd_pkg::ST_NEG: begin
        if (!enable) begin
          state_d = lcd_pkg::ST_OFF;
        end else if (step) begin
          state_d = lcd_pkg::ST_POS;
          com_d = (com_q == com_last) ? 2'h0 : com_q + 2'h1;
        end
      end
      default: state_d = lcd_pkg::ST_OFF;
    endcase
    if (state_d == lcd_pkg::ST_OFF) com_d = 2'h0;
  end

  always_comb begin
    drive_d = '0;
    if (state_q != lcd_pkg::ST_OFF) begin
      for (int c = 0; c < lcd_pkg::COM_PINS; c++) begin
        if (c < DUTY) drive_d.com[c] = com_lvl(com_q == 2'(c), neg);
      end
      for (int s = 0; s < lcd_pkg::SEG_NUM; s++) begin
        drive_d.seg[s] = seg_lvl(seg_bits[s], neg);
      end
      if (DUTY == 4) drive_d.seg[lcd_pkg::SEG_NUM-1] = com_lvl(com_q == 2'h3, neg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lcd_pkg::ST_OFF;
      com_q <= 2'h0;
      drive <= '0;
    end else begin
      state_q <= state_d;
      com_q <= com_d;
      drive <= drive_d;
    end
  end

  sequence s_neg_step;
    state_q == lcd_pkg::ST_NEG && enable && step;
  endsequence

  chk_common_advance: assert property (@(posedge pclk) disable iff (!presetn)
    s_neg_step |=> com_q == (($past(com_q) == com_last) ? 2'h0 : $past(com_q) + 2'h1))
    else $error("active common did not advance in cyclic order");
  chk_pixel_on_level: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == lcd_pkg::ST_POS && seg_bits[0] |=> drive.seg[0] == lcd_pkg::LVL_GND)
    else $error("lit pixel segment not driven opposite to its common");
  chk_fourth_common: assert property (@(posedge pclk) disable iff (!presetn)
    DUTY == 4 && state_q == lcd_pkg::ST_POS && com_q == 2'h3
    |=> drive.seg[lcd_pkg::SEG_NUM-1] == lcd_pkg::LVL_TOP)
    else $error("highest segment pin not acting as fourth common");
endmodule // lcd_scan
`default_nettype wire

// ==== include/lcd_pkg.sv ====
// Purpose: Shared constants and types of the segment LCD display-memory driver.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Level codes name the four drive rails; half bias uses only GND, LOW and TOP.
`default_nettype none
package lcd_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PTR = 12'h004;
  localparam logic [11:0] OFF_IND = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_WIN = 12'h100;
  localparam logic [11:0] OFF_WIN_LAST = 12'h180;
  localparam logic [7:0] DISP_LO = 8'h40;
  localparam logic [7:0] DISP_HI = 8'h60;
  localparam int SEG_NUM = 33;
  localparam int COM_PINS = 3;
  localparam int MEM_WORDS = 33;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic BANK_RST = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam int SYS_DIV4_CNT = 4;
  localparam logic [1:0] PRE_LAST = 2'h3;

  typedef enum logic [1:0] {
    LVL_GND = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP = 2'h3
  } level_e;

  typedef enum logic [1:0] {
    SRC_SYS_DIV4 = 2'h0,
    SRC_TIMEKEEP = 2'h1,
    SRC_WATCHDOG = 2'h2
  } clk_src_e;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_POS = 3'b010,
    ST_NEG = 3'b100
  } scan_e;

  typedef struct packed {
    logic [COM_PINS-1:0][1:0] com;
    logic [SEG_NUM-1:0][1:0] seg;
  } lcd_drive_s;

  typedef struct packed {
    logic blank;
    logic neg;
    logic [1:0] com;
  } scan_status_s;
endpackage
`default_nettype wire

// ==== tb/lcd_display_memory_driver_tb.sv ====
// Purpose: Self-checking bench for the display memory driver over APB and the glass.
// Assumes: Four commons, third bias, system clock over four, display off in halt.
// Notes: The divider exponent is cut to two so a scan step lasts sixteen clocks.
`timescale 1ns/1ps
`default_nettype none
module lcd_display_memory_driver_tb;
  localparam int DIV_EXP = 2;
  localparam int STEP = 4 * (2 ** DIV_EXP);
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, cpu_halt, tk_tick, wd_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, bank_select_bit, e, neg, any_volt;
  lcd_pkg::lcd_drive_s drive;
  logic [3:0][32:0] lit;
  int n_active, act, miscompares = 0, checks_done = 0;
  logic [7:0] disp [33];
  always #2.5 pclk = ~pclk;
  lcd_display_memory_driver #(.DUTY(4), .THIRD_BIAS(1'b1), .LOW_VOLT(1'b0), .DIV_EXP(DIV_EXP),
    .CLK_SRC(lcd_pkg::SRC_SYS_DIV4), .HALT_KEEP_ON(1'b0)) lcd_display_memory_driver_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_halt(cpu_halt), .timekeeping_oscillator_tick(tk_tick), .watchdog_oscillator_tick(wd_tick),
    .bank_select_bit(bank_select_bit), .drive(drive));
  lcd_glass #(.DUTY(4)) lcd_glass_i (.drive(drive), .lit(lit), .n_active(n_active), .act(act),
    .neg(neg), .any_volt(any_volt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Wide enough for the whole drive struct so no pin escapes the halt comparison.
  task automatic chk(input string n, input logic [127:0] s, input logic [127:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk("pslverr", e, ee);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", v, x);
    chk("pslverr", e, ee);
  endtask
  task automatic wait_step(output int cyc);
    lcd_pkg::lcd_drive_s prev;
    prev = drive;
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
    end while (drive === prev && cyc < 200);
    if (cyc >= 200) begin
      miscompares++;
      close_out();
    end
  endtask
  // Two full frames: every half step is timed, ordered and compared pixel by pixel.
  task automatic frame();
    int cyc, pa, ea;
    logic pn;
    logic [32:0] row;
    wait_step(cyc);
    pa = act;
    pn = neg;
    for (int k = 0; k < 16; k++) begin
      wait_step(cyc);
      ea = pn ? (pa + 1) % 4 : pa;
      chk("step_cycles", cyc, STEP);
      chk("active_count", n_active, 1);
      chk("active_common", act, ea);
      chk("half", neg, !pn);
      row = '0;
      for (int s = 0; s < 32; s++) row[s] = disp[s][ea];
      chk("pixels", lit[ea], row);
      for (int c = 0; c < 3; c++) begin
        if (c != ea) chk("idle_common", drive.com[c], neg ? lcd_pkg::LVL_HIGH : lcd_pkg::LVL_LOW);
      end
      pa = act;
      pn = neg;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cpu_halt = 1'b0;
    tk_tick = 1'b0;
    wd_tick = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(lcd_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
    rd(12'h010, 32'h0000_0000, 1'b1);
    wr(lcd_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
    // The write lands at the access edge itself, so look once the register has settled.
    #1;
    chk("bank_select_bit", bank_select_bit, 1'b1);
    for (int s = 0; s < 33; s++) begin
      disp[s] = 8'((s * 5 + 1) & 15);
      wr(lcd_pkg::OFF_PTR, 32'(8'h40 + s), 1'b0);
      wr(lcd_pkg::OFF_IND, 32'(disp[s]), 1'b0);
    end
    wr(lcd_pkg::OFF_PTR, 32'h0000_0045, 1'b0);
    rd(lcd_pkg::OFF_IND, 32'(disp[5]), 1'b0);
    // Bank zero traffic on the same addresses must land in general memory only.
    wr(lcd_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
    for (int s = 0; s < 33; s++) begin
      wr(lcd_pkg::OFF_PTR, 32'(8'h40 + s), 1'b0);
      wr(lcd_pkg::OFF_IND, 32'(8'ha0 + s), 1'b0);
      rd(12'(lcd_pkg::OFF_WIN + 4 * s), 32'(8'ha0 + s), 1'b0);
    end
    wr(lcd_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
    wr(lcd_pkg::OFF_WIN, 32'h0000_003c, 1'b0);
    rd(lcd_pkg::OFF_WIN, 32'h0000_003c, 1'b0);
    wr(lcd_pkg::OFF_PTR, 32'h0000_003f, 1'b0);
    rd(lcd_pkg::OFF_IND, 32'h0000_0000, 1'b0);
    wr(lcd_pkg::OFF_PTR, 32'h0000_0061, 1'b0);
    wr(lcd_pkg::OFF_IND, 32'h0000_00ff, 1'b0);
    rd(lcd_pkg::OFF_IND, 32'h0000_0000, 1'b0);
    rd(lcd_pkg::OFF_PTR, 32'h0000_0061, 1'b0);
    wr(lcd_pkg::OFF_STAT, 32'h0000_000f, 1'b1);
    frame();
    disp[7] = 8'h0f;
    wr(lcd_pkg::OFF_PTR, 32'h0000_0047, 1'b0);
    wr(lcd_pkg::OFF_IND, 32'h0000_000f, 1'b0);
    // The new byte reaches the pins one edge later; without this wait the frame would sync on it.
    repeat (2) @(posedge pclk);
    frame();
    // Halting must blank the glass with zero net voltage and stop the scan, which restarts at common 0.
    @(posedge pclk);
    cpu_halt <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("halt_drive", drive, '0);
    chk("halt_volts", any_volt, 1'b0);
    apb(1'b0, lcd_pkg::OFF_STAT, 32'h0000_0000);
    chk("halt_blank", v[3], 1'b1);
    repeat (40) @(posedge pclk);
    #1;
    chk("halt_hold", drive, '0);
    @(posedge pclk);
    cpu_halt <= 1'b0;
    rd(lcd_pkg::OFF_STAT, 32'h0000_0000, 1'b0);
    frame();
    close_out();
  end
endmodule // lcd_display_memory_driver_tb
`default_nettype wire

// ==== tb/lcd_glass.sv ====
// Purpose: Passive segment glass that turns common and segment levels into pixel states.
// Assumes: Level codes are evenly spaced steps between ground and the top rail.
// Notes: A pixel lights only across the full rail span, which is how real glass thresholds.
`timescale 1ns/1ps
`default_nettype none
module lcd_glass #(
  parameter int DUTY = 4
) (
  input wire lcd_pkg::lcd_drive_s drive,
  output logic [3:0][32:0] lit,
  output int n_active,
  output int act,
  output logic neg,
  output logic any_volt
);
  ////////////////////////////////////////////////////////////////////////////
  // With four commons the top segment pin is the fourth common line.
  always_comb begin
    int d;
    logic [1:0] cl;
    d = 0;
    cl = 2'h0;
    lit = '0;
    n_active = 0;
    act = -1;
    neg = 1'b0;
    any_volt = 1'b0;
    for (int c = 0; c < DUTY; c++) begin
      if (c < 3) cl = drive.com[c];
      else cl = drive.seg[32];
      if (cl == lcd_pkg::LVL_TOP || cl == lcd_pkg::LVL_GND) begin
        n_active++;
        act = c;
        neg = (cl == lcd_pkg::LVL_GND);
      end
      for (int s = 0; s < 33; s++) begin
        if (s < 32 || DUTY < 4) begin
          d = int'(cl) - int'(drive.seg[s]);
          if (d != 0) any_volt = 1'b1;
          if (d == 3 || d == -3) lit[c][s] = 1'b1;
        end
      end
    end
  end
endmodule // lcd_glass
`default_nettype wire
